//--- src/srir_pkg.sv
// Shared constants and types of the software-reset and interrupt-return unit.
// Assumes a 25 MHz core clock and an AXI4-Lite register port with 12 address bits.
package srir_pkg;

    // Bus geometry and answers
    localparam int          ADDR_W       = 12;
    localparam int          DATA_W       = 32;
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;

    // Register byte offsets
    localparam logic [11:0] OFS_STATUS     = 12'h000;
    localparam logic [11:0] OFS_CORE_CTRL  = 12'h004;
    localparam logic [11:0] OFS_RESET_CTRL = 12'h008;
    localparam logic [11:0] OFS_STACK_PTR  = 12'h00c;
    localparam logic [11:0] OFS_PC_LOW     = 12'h010;
    localparam logic [11:0] OFS_PC_HIGH    = 12'h014;
    localparam logic [11:0] OFS_EXEC_STATE = 12'h018;
    localparam logic [11:0] OFS_STACK_BASE = 12'h100;

    // Field positions
    localparam int          SOFT_RST_FLAG_BIT = 6;
    localparam int          PRIO_BIT3_POS     = 3;
    localparam int          FRAME_ACTIVE_BIT  = 2;

    // Power-on values
    localparam logic [15:0] STATUS_RST     = 16'h0000;
    localparam logic [15:0] CORE_CTRL_RST  = 16'h0020;
    localparam logic [15:0] RESET_CTRL_RST = 16'h0000;
    localparam logic [15:0] STACK_PTR_RST  = 16'h0800;
    localparam logic [22:0] PC_RST         = 23'h000000;

    // Opcodes
    localparam logic [23:0] OPC_SOFT_RESET = 24'hfe0000;
    localparam logic [23:0] OPC_RET_INTR   = 24'h064000;

    // Timing counts in core cycles, and the stack pointer step in bytes
    localparam logic [2:0]  RETI_CYCLES_EARLY = 3'h3;
    localparam logic [2:0]  RETI_CYCLES_LATE  = 3'h6;
    localparam logic [2:0]  EXC_SAVING        = 3'h1;
    localparam logic [2:0]  POP_LOW_CYCLE     = 3'h2;
    localparam logic [15:0] STACK_STEP        = 16'h0002;

    typedef enum logic [2:0] {
        ST_IDLE    = 3'b001,
        ST_POP_LOW = 3'b010,
        ST_HOLD    = 3'b100
    } srir_state_type;

    typedef struct packed {
        logic [11:0] awaddr;
        logic        awvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        wvalid;
        logic        bready;
        logic [11:0] araddr;
        logic        arvalid;
        logic        rready;
    } srir_axi_req_type;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic [1:0]  bresp;
        logic        bvalid;
        logic        arready;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic        rvalid;
    } srir_axi_rsp_type;

    typedef struct packed {
        logic [23:0] word;
        logic        valid;
        logic        excPending;
    } srir_instr_type;

endpackage

//--- src/srir_stack_ram.sv
// Small stack memory of 16-bit words with byte enables and a registered read port.
// Assumes one clock; write and read ports are independent.
`timescale 1ns/1ns
module srir_stack_ram #(
    parameter int DEPTH = 32,
    parameter int AW    = $clog2(DEPTH)
) (
    // Clock
    input  wire logic          clk,
    // Write port
    input  wire logic          writeEn,
    input  wire logic [AW-1:0] writeAddr,
    input  wire logic [15:0]   writeData,
    input  wire logic [1:0]    writeStrb,
    // Read port
    input  wire logic [AW-1:0] readAddr,
    output logic      [15:0]   readData
);

    logic [15:0] mem [DEPTH];

    always_ff @(posedge clk) begin
        if (writeEn && writeStrb[0]) begin
            mem[writeAddr][7:0] <= writeData[7:0];
        end
        if (writeEn && writeStrb[1]) begin
            mem[writeAddr][15:8] <= writeData[15:8];
        end
    end

    always_ff @(posedge clk) begin
        readData <= mem[readAddr];
    end

endmodule

//--- src/srir_core.sv
// Execution unit for the software reset and return-from-interrupt instructions,
// with its core registers and a small stack memory behind an AXI4-Lite slave.
// Assumes the fetch stage offers one instruction word at a time on the core clock.
//
// How it works
// - Opcode fe0000 is the software reset: one word, done in one cycle.
// - Software reset returns every register to its power-on value; here reset control keeps its other bits.
// - Software reset loads the program counter with zero.
// - Software reset sets the software reset flag, bit 6 of reset control.
// - Status flags, priority level and stack frame active bit go back to reset.
// - Opcode 064000 is return from interrupt: one word, no operands.
// - First pop: pointer minus 2, status low byte, priority bit 3, pc high bits.
// - Second pop: pointer minus 2 again, pc low word, prefetched word becomes a no-op.
// - Later variant loads pc bits 15:1 and puts stack bit 0 in stack frame active.
// - Priority bit 3, repeat flag and arithmetic flags come back from the stack.
// - Earlier variant takes 3 cycles, 2 with an exception pending.
// - Later variant takes 6 cycles, 5 with an exception pending.
//
// The implementer's own choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ns
module srir_core #(
    parameter bit LATE_VARIANT = 1'b0,
    parameter int STACK_DEPTH  = 32
) (
    // Clock and reset
    input  wire logic                      clk,
    input  wire logic                      nrst,
    // Register bus
    input  wire srir_pkg::srir_axi_req_type axiReq,
    output srir_pkg::srir_axi_rsp_type      axiRsp,
    // Instruction from fetch
    input  wire srir_pkg::srir_instr_type   instr,
    output logic                            instrReady,
    output logic                            instrDone,
    // Effects on the rest of the core
    output logic                            fetchFlush,
    output logic                            softResetPulse,
    output logic [22:0]                     pcOut
);

    localparam int AW = $clog2(STACK_DEPTH);
    localparam logic [11:0] STACK_END = 12'(int'(srir_pkg::OFS_STACK_BASE) + STACK_DEPTH * 4);
    localparam logic [2:0] RETI_CYCLES = LATE_VARIANT ? srir_pkg::RETI_CYCLES_LATE
                                                      : srir_pkg::RETI_CYCLES_EARLY;

    ////////////////////////////////////////////////////////////////////////////
    // Declarations

    srir_pkg::srir_state_type state;
    srir_pkg::srir_state_type next_state;
    logic [2:0]  cycleCount;
    logic [2:0]  targetCycles;
    logic [15:0] status;
    logic [15:0] coreCtrl;
    logic [15:0] resetCtrl;
    logic [15:0] stackPtr;
    logic [15:0] next_stackPtr;
    logic [15:0] popAddr;
    logic [15:0] stackWord;
    logic        isSoftReset;
    logic        isRetIntr;
    logic        inPopLow;
    logic        lastCycle;

    logic        awReady;
    logic        wReady;
    logic        bValid;
    logic [1:0]  bResp;
    logic        arReady;
    logic        rValid;
    logic [31:0] rData;
    logic [1:0]  rResp;
    logic [11:0] wrAddr;
    logic [15:0] wrData;
    logic [1:0]  wrStrb;
    logic        wrFire;
    logic        wrRamHit;
    logic        rdRamHit;

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] data,
                                            input logic [1:0] strb);
        logic [15:0] result;
        result = old;
        if (strb[0]) begin
            result[7:0] = data[7:0];
        end
        if (strb[1]) begin
            result[15:8] = data[15:8];
        end
        return result;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Instruction decode and sequencing

    assign isSoftReset = (state == srir_pkg::ST_IDLE) && instr.valid
                         && (instr.word == srir_pkg::OPC_SOFT_RESET);
    assign isRetIntr   = (state == srir_pkg::ST_IDLE) && instr.valid
                         && (instr.word == srir_pkg::OPC_RET_INTR);
    assign inPopLow    = (state == srir_pkg::ST_POP_LOW);
    assign lastCycle   = (inPopLow && (targetCycles == srir_pkg::POP_LOW_CYCLE))
                         || ((state == srir_pkg::ST_HOLD) && (3'(cycleCount + 3'h1) == targetCycles));

    always_comb begin
        next_state = state;
        case (state)
            srir_pkg::ST_IDLE: begin
                if (isRetIntr) begin
                    next_state = srir_pkg::ST_POP_LOW;
                end
            end
            srir_pkg::ST_POP_LOW: begin
                next_state = lastCycle ? srir_pkg::ST_IDLE : srir_pkg::ST_HOLD;
            end
            srir_pkg::ST_HOLD: begin
                if (lastCycle) begin
                    next_state = srir_pkg::ST_IDLE;
                end
            end
            default: begin
                next_state = srir_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            state <= srir_pkg::ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Cycle budget is fixed at acceptance; a pending exception saves one cycle
    always_ff @(posedge clk) begin
        if (!nrst) begin
            targetCycles <= srir_pkg::RETI_CYCLES_EARLY;
            cycleCount   <= 3'h0;
        end else if (isRetIntr) begin
            targetCycles <= instr.excPending ? 3'(RETI_CYCLES - srir_pkg::EXC_SAVING)
                                             : RETI_CYCLES;
            cycleCount   <= 3'h1;
        end else if (state != srir_pkg::ST_IDLE) begin
            cycleCount   <= 3'(cycleCount + 3'h1);
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            instrReady     <= 1'b0;
            instrDone      <= 1'b0;
            fetchFlush     <= 1'b0;
            softResetPulse <= 1'b0;
        end else begin
            instrReady     <= (next_state == srir_pkg::ST_IDLE);
            instrDone      <= isSoftReset || lastCycle;
            fetchFlush     <= inPopLow;
            softResetPulse <= isSoftReset;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Stack pointer and stack memory

    // The read address follows the next pointer so each popped word is ready when needed
    always_comb begin
        next_stackPtr = stackPtr;
        if (isSoftReset) begin
            next_stackPtr = srir_pkg::STACK_PTR_RST;
        end else if (isRetIntr || inPopLow) begin
            next_stackPtr = 16'(stackPtr - srir_pkg::STACK_STEP);
        end else if (wrFire && (wrAddr == srir_pkg::OFS_STACK_PTR)) begin
            next_stackPtr = merge16(stackPtr, wrData, wrStrb);
        end
    end

    assign popAddr = 16'(next_stackPtr - srir_pkg::STACK_STEP);

    always_ff @(posedge clk) begin
        if (!nrst) begin
            stackPtr <= srir_pkg::STACK_PTR_RST;
        end else begin
            stackPtr <= next_stackPtr;
        end
    end

    srir_stack_ram #(
        .DEPTH (STACK_DEPTH),
        .AW    (AW)
    ) u_stack_ram (
        .clk       (clk),
        .writeEn   (wrFire && wrRamHit),
        .writeAddr (wrAddr[AW+1:2]),
        .writeData (wrData),
        .writeStrb (wrStrb),
        .readAddr  (popAddr[AW:1]),
        .readData  (stackWord)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Core registers

    always_ff @(posedge clk) begin
        if (!nrst || isSoftReset) begin
            status <= srir_pkg::STATUS_RST;
        end else if (isRetIntr) begin
            status[7:0] <= stackWord[15:8];
        end else if (wrFire && (wrAddr == srir_pkg::OFS_STATUS)) begin
            status <= merge16(status, wrData, wrStrb);
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst || isSoftReset) begin
            coreCtrl <= srir_pkg::CORE_CTRL_RST;
        end else begin
            if (wrFire && (wrAddr == srir_pkg::OFS_CORE_CTRL)) begin
                coreCtrl <= merge16(coreCtrl, wrData, wrStrb);
            end
            if (isRetIntr) begin
                coreCtrl[srir_pkg::PRIO_BIT3_POS] <= stackWord[7];
            end
            if (inPopLow && LATE_VARIANT) begin
                coreCtrl[srir_pkg::FRAME_ACTIVE_BIT] <= stackWord[0];
            end
        end
    end

    // The reset flag survives the software reset; a set beats a software clear
    always_ff @(posedge clk) begin
        if (!nrst) begin
            resetCtrl <= srir_pkg::RESET_CTRL_RST;
        end else begin
            if (wrFire && (wrAddr == srir_pkg::OFS_RESET_CTRL)) begin
                resetCtrl <= merge16(resetCtrl, wrData, wrStrb);
            end
            if (isSoftReset) begin
                resetCtrl[srir_pkg::SOFT_RST_FLAG_BIT] <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst || isSoftReset) begin
            pcOut <= srir_pkg::PC_RST;
        end else if (isRetIntr) begin
            pcOut[22:16] <= stackWord[6:0];
        end else if (inPopLow) begin
            if (LATE_VARIANT) begin
                pcOut[15:1] <= stackWord[15:1];
                pcOut[0]    <= 1'b0;
            end else begin
                pcOut[15:0] <= stackWord;
            end
        end else if (wrFire && (wrAddr == srir_pkg::OFS_PC_LOW)) begin
            pcOut[15:0] <= merge16(pcOut[15:0], wrData, wrStrb);
        end else if (wrFire && (wrAddr == srir_pkg::OFS_PC_HIGH) && wrStrb[0]) begin
            pcOut[22:16] <= wrData[6:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write side

    assign wrFire   = !awReady && !wReady && !bValid;
    assign wrRamHit = (wrAddr >= srir_pkg::OFS_STACK_BASE) && (wrAddr < STACK_END);

    always_ff @(posedge clk) begin
        if (!nrst) begin
            awReady <= 1'b1;
            wrAddr  <= 12'h000;
        end else if (axiReq.awvalid && awReady) begin
            awReady <= 1'b0;
            wrAddr  <= {axiReq.awaddr[11:2], 2'h0};
        end else if (wrFire) begin
            awReady <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            wReady <= 1'b1;
            wrData <= 16'h0000;
            wrStrb <= 2'h0;
        end else if (axiReq.wvalid && wReady) begin
            wReady <= 1'b0;
            wrData <= axiReq.wdata[15:0];
            wrStrb <= axiReq.wstrb[1:0];
        end else if (wrFire) begin
            wReady <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            bValid <= 1'b0;
            bResp  <= srir_pkg::RESP_OKAY;
        end else if (wrFire) begin
            bValid <= 1'b1;
            bResp  <= (wrAddr <= srir_pkg::OFS_PC_HIGH || wrRamHit) ? srir_pkg::RESP_OKAY
                                                                    : srir_pkg::RESP_SLVERR;
        end else if (bValid && axiReq.bready) begin
            bValid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read side

    assign rdRamHit = (axiReq.araddr >= srir_pkg::OFS_STACK_BASE) && (axiReq.araddr < STACK_END);

    always_ff @(posedge clk) begin
        if (!nrst) begin
            arReady <= 1'b1;
            rValid  <= 1'b0;
            rData   <= 32'h00000000;
            rResp   <= srir_pkg::RESP_OKAY;
        end else if (axiReq.arvalid && arReady) begin
            arReady <= 1'b0;
            rValid  <= 1'b1;
            rResp   <= srir_pkg::RESP_OKAY;
            case ({axiReq.araddr[11:2], 2'h0})
                srir_pkg::OFS_STATUS:     rData <= {16'h0000, status};
                srir_pkg::OFS_CORE_CTRL:  rData <= {16'h0000, coreCtrl};
                srir_pkg::OFS_RESET_CTRL: rData <= {16'h0000, resetCtrl};
                srir_pkg::OFS_STACK_PTR:  rData <= {16'h0000, stackPtr};
                srir_pkg::OFS_PC_LOW:     rData <= {16'h0000, pcOut[15:0]};
                srir_pkg::OFS_PC_HIGH:    rData <= {25'h0000000, pcOut[22:16]};
                srir_pkg::OFS_EXEC_STATE: rData <= {26'h0000000, cycleCount, state};
                default: begin
                    // Stack window is write-only and reads as zero
                    rData <= 32'h00000000;
                    if (!rdRamHit) begin
                        rResp <= srir_pkg::RESP_SLVERR;
                    end
                end
            endcase
        end else if (rValid && axiReq.rready) begin
            arReady <= 1'b1;
            rValid  <= 1'b0;
        end
    end

    assign axiRsp = '{awready: awReady, wready: wReady, bresp: bResp, bvalid: bValid,
                      arready: arReady, rdata: rData, rresp: rResp, rvalid: rValid};

endmodule

//--- dv/srir_core_properties.sv
// Concurrent checks on the instruction port and its effects.
// Assumes it is bound into every srir_core instance and sees only its ports.
`timescale 1ns/1ns
module srir_core_properties #(
    parameter bit LATE_VARIANT = 1'b0,
    parameter int STACK_DEPTH  = 32
) (
    // Clock and reset
    input wire logic                       clk,
    input wire logic                       nrst,
    // Register bus
    input wire srir_pkg::srir_axi_req_type axiReq,
    input wire srir_pkg::srir_axi_rsp_type axiRsp,
    // Instruction port and effects
    input wire srir_pkg::srir_instr_type   instr,
    input wire logic                       instrReady,
    input wire logic                       instrDone,
    input wire logic                       fetchFlush,
    input wire logic                       softResetPulse,
    input wire logic [22:0]                pcOut
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    logic softRstAcc;
    logic retiAcc;
    assign softRstAcc = instrReady && instr.valid && instr.word == srir_pkg::OPC_SOFT_RESET;
    assign retiAcc = instrReady && instr.valid && instr.word == srir_pkg::OPC_RET_INTR;

    // Second pop lands one cycle after the first
    sequence s_two_pops;
        !fetchFlush ##1 fetchFlush;
    endsequence

    a_soft_reset_done: assert property (softRstAcc |=> instrDone && softResetPulse)
        else $error("soft reset not finished in one cycle");
    a_soft_reset_pc: assert property (softRstAcc |=> pcOut == 23'h0)
        else $error("program counter not zero after soft reset");
    a_early_full: assert property (retiAcc && !LATE_VARIANT && !instr.excPending
        |=> !instrDone[*2] ##1 instrDone)
        else $error("early return length wrong");
    a_early_short: assert property (retiAcc && !LATE_VARIANT && instr.excPending
        |=> !instrDone ##1 instrDone)
        else $error("early return length wrong with exception");
    a_late_full: assert property (retiAcc && LATE_VARIANT && !instr.excPending
        |=> !instrDone[*5] ##1 instrDone)
        else $error("late return length wrong");
    a_late_short: assert property (retiAcc && LATE_VARIANT && instr.excPending
        |=> !instrDone[*4] ##1 instrDone)
        else $error("late return length wrong with exception");
    a_flush_after_pops: assert property (retiAcc |=> s_two_pops)
        else $error("flush not after second pop");
    a_flush_once: assert property (fetchFlush |=> !fetchFlush)
        else $error("flush longer than one cycle");
endmodule

bind srir_core srir_core_properties #(.LATE_VARIANT(LATE_VARIANT), .STACK_DEPTH(STACK_DEPTH))
    srir_core_properties_inst (
    .clk(clk), .nrst(nrst), .axiReq(axiReq), .axiRsp(axiRsp), .instr(instr), .instrReady(instrReady),
    .instrDone(instrDone), .fetchFlush(fetchFlush), .softResetPulse(softResetPulse), .pcOut(pcOut));

//--- dv/srir_core_test.sv
// Self-checking bench: both core variants run side by side on one stimulus.
// Assumes srir_pkg and srir_core are compiled before it.
`timescale 1ns/1ns
module srir_core_test;
    logic                       clk;
    logic                       nrst;
    srir_pkg::srir_axi_req_type axiReq;
    srir_pkg::srir_axi_rsp_type axiRsp [2];
    srir_pkg::srir_instr_type   instr;
    logic                       instrReady [2];
    logic                       instrDone [2];
    logic                       fetchFlush [2];
    logic                       softResetPulse [2];
    logic [22:0]                pcOut [2];
    int                         error_cnt;
    int                         checks;
    // Reference model: index 0 early variant, 1 late variant
    int                         statusExp;
    int                         rc;
    int                         sp;
    int                         cc [2];
    int                         pc [2];

    for (genvar g = 0; g < 2; g++) begin : gen_core
        srir_core #(.LATE_VARIANT(g == 1), .STACK_DEPTH(32)) srir_core_inst (
            .clk(clk), .nrst(nrst), .axiReq(axiReq), .axiRsp(axiRsp[g]), .instr(instr),
            .instrReady(instrReady[g]), .instrDone(instrDone[g]), .fetchFlush(fetchFlush[g]),
            .softResetPulse(softResetPulse[g]), .pcOut(pcOut[g]));
    end

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic summarize;
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tmo(input logic ok);
        if (ok !== 1'b1) begin
            error_cnt++;
            summarize();
        end
    endtask

    task automatic axi_wr(input logic [11:0] a, input logic [15:0] d, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge clk);
        axiReq.awaddr  <= a;
        axiReq.wdata   <= {16'h0, d};
        axiReq.wstrb   <= 4'h3;
        axiReq.awvalid <= 1'b1;
        axiReq.wvalid  <= 1'b1;
        axiReq.bready  <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (axiReq.awvalid && axiRsp[0].awready) axiReq.awvalid <= 1'b0;
            if (axiReq.wvalid && axiRsp[0].wready) axiReq.wvalid <= 1'b0;
        end while (!axiRsp[0].bvalid && n < 40);
        axiReq.bready <= 1'b0;
        tmo(axiRsp[0].bvalid);
        chk(axiRsp[0].bresp, er, "bresp early");
        chk(axiRsp[1].bresp, er, "bresp late");
    endtask

    task automatic rchk(input logic [11:0] a, input logic [31:0] e0, input logic [31:0] e1, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge clk);
        axiReq.araddr  <= a;
        axiReq.arvalid <= 1'b1;
        axiReq.rready  <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (axiReq.arvalid && axiRsp[0].arready) axiReq.arvalid <= 1'b0;
        end while (!axiRsp[0].rvalid && n < 40);
        axiReq.rready <= 1'b0;
        tmo(axiRsp[0].rvalid);
        chk(axiRsp[0].rdata, e0, "rdata early");
        chk(axiRsp[1].rdata, e1, "rdata late");
        chk(axiRsp[0].rresp, er, "rresp");
    endtask

    task automatic regs_chk;
        rchk(srir_pkg::OFS_STATUS, statusExp, statusExp, srir_pkg::RESP_OKAY);
        rchk(srir_pkg::OFS_CORE_CTRL, cc[0], cc[1], srir_pkg::RESP_OKAY);
        rchk(srir_pkg::OFS_RESET_CTRL, rc, rc, srir_pkg::RESP_OKAY);
        rchk(srir_pkg::OFS_STACK_PTR, sp, sp, srir_pkg::RESP_OKAY);
        rchk(srir_pkg::OFS_PC_LOW, pc[0] & 'hffff, pc[1] & 'hffff, srir_pkg::RESP_OKAY);
        rchk(srir_pkg::OFS_PC_HIGH, pc[0] >> 16, pc[1] >> 16, srir_pkg::RESP_OKAY);
    endtask

    // Offer one word, then count cycles to done and flush pulses per variant
    task automatic exec(input logic [23:0] w, input logic x, input int e0, input int e1, input int ef);
        int dn [2];
        int fl [2];
        int sw [2];
        dn = '{0, 0};
        fl = '{0, 0};
        sw = '{0, 0};
        @(posedge clk);
        instr <= '{word: w, valid: 1'b1, excPending: x};
        @(posedge clk);
        instr.valid <= 1'b0;
        chk(instrReady[0] & instrReady[1], 1'b1, "instrReady");
        for (int n = 1; n < 12; n++) begin
            @(posedge clk);
            for (int g = 0; g < 2; g++) begin
                if (instrDone[g] === 1'b1 && dn[g] == 0) dn[g] = n;
                if (fetchFlush[g] === 1'b1) fl[g]++;
                if (softResetPulse[g] === 1'b1) sw[g]++;
            end
        end
        chk(dn[0], e0, "done cycle early");
        chk(dn[1], e1, "done cycle late");
        for (int g = 0; g < 2; g++) begin
            chk(pcOut[g], pc[g], "pcOut");
            chk(sw[g], (w == srir_pkg::OPC_SOFT_RESET), "soft reset pulses");
            if (w != srir_pkg::OPC_SOFT_RESET) chk(fl[g], ef, "flush pulses");
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [15:0] t1;
        logic [15:0] t2;
        logic [15:0] s0;
        logic [15:0] c0;
        int          i1;
        axiReq = '0;
        instr = '0;
        nrst = 1'b0;
        error_cnt = 0;
        checks = 0;
        void'($urandom(32'h8575));
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        statusExp = 0;
        rc = 0;
        sp = 'h800;
        cc = '{'h20, 'h20};
        pc = '{0, 0};
        regs_chk();
        // Idle state after reset: count 0, state code idle; stack window reads zero
        rchk(srir_pkg::OFS_EXEC_STATE, 32'h1, 32'h1, srir_pkg::RESP_OKAY);
        rchk(srir_pkg::OFS_STACK_BASE, 0, 0, srir_pkg::RESP_OKAY);
        axi_wr(12'h020, 16'hffff, srir_pkg::RESP_SLVERR);
        rchk(12'h020, 0, 0, srir_pkg::RESP_SLVERR);
        for (int i = 0; i < 8; i++) begin
            sp = 2 * $urandom_range(32767, 2);
            t1 = 16'($urandom);
            t2 = 16'($urandom);
            s0 = 16'($urandom);
            c0 = 16'($urandom);
            i1 = ((sp - 2) >> 1) % 32;
            axi_wr(srir_pkg::OFS_STACK_BASE + 12'(4 * i1), t1, srir_pkg::RESP_OKAY);
            axi_wr(srir_pkg::OFS_STACK_BASE + 12'(4 * ((i1 + 31) % 32)), t2, srir_pkg::RESP_OKAY);
            axi_wr(srir_pkg::OFS_STACK_PTR, 16'(sp), srir_pkg::RESP_OKAY);
            axi_wr(srir_pkg::OFS_STATUS, s0, srir_pkg::RESP_OKAY);
            axi_wr(srir_pkg::OFS_CORE_CTRL, c0, srir_pkg::RESP_OKAY);
            statusExp = {s0[15:8], t1[15:8]};
            cc[0] = {c0[15:4], t1[7], c0[2:0]};
            cc[1] = {c0[15:4], t1[7], t2[0], c0[1:0]};
            pc[0] = {t1[6:0], t2};
            pc[1] = {t1[6:0], t2[15:1], 1'b0};
            sp = sp - 4;
            // Service code is taken to have cleared its source flag before each return
            exec(srir_pkg::OPC_RET_INTR, i[0], i[0] ? 2 : 3, i[0] ? 5 : 6, 1);
            regs_chk();
        end
        for (int k = 0; k < 2; k++) begin
            exec(k ? 24'hfe0001 : 24'h064001, 1'b0, 0, 0, 0);
        end
        axi_wr(srir_pkg::OFS_RESET_CTRL, 16'h0011, srir_pkg::RESP_OKAY);
        statusExp = 0;
        rc = 'h51;
        sp = 'h800;
        cc = '{'h20, 'h20};
        pc = '{0, 0};
        exec(srir_pkg::OPC_SOFT_RESET, 1'b0, 1, 1, 0);
        regs_chk();
        summarize();
    end
endmodule
